// ===== verilog/irq_src_pkg.sv
package irq_src_pkg;
  localparam int NUM_ENDPOINTS = 5;
  localparam int NUM_DAC_PINS = 8;
  localparam int NUM_GPIO_PORTS = 4;
  localparam int PORT_WIDTH = 8;
  localparam int GPIO_PINS = NUM_GPIO_PORTS * PORT_WIDTH;
  // Vector addresses of the three shared requests
  localparam logic [15:0] VEC_DAC = 16'h0014;
  localparam logic [15:0] VEC_GPIO = 16'h0016;
  localparam logic [15:0] VEC_I2C = 16'h0018;
  localparam logic [15:0] VEC_NONE = 16'h0000;
  // Global enable bit that gates the parallel host port request
  localparam int GLOBAL_HOST_PORT_BIT = 5;
  localparam int GLOBAL_EN_WIDTH = 8;
  // Port configuration code for the mode with enables affecting CMOS drive
  localparam logic [1:0] PORT_CFG_CMOS_IRQ = 2'h2;
  typedef enum logic [2:0] {
    I2C_IDLE,
    I2C_SLAVE_RX,
    I2C_SLAVE_TX,
    I2C_MASTER_TX,
    I2C_MASTER_RX
  } i2c_mode_type;
endpackage

// ===== verilog/pin_edge_lock.sv
`timescale 1ns/1ps
// Shared pin request: OR of enabled, polarity-adjusted synchronised levels, rising edge
module pin_edge_lock #(
  parameter int WIDTH = 8
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_reset,
  // Pins and settings
  input wire logic [WIDTH-1:0] i_pins,
  input wire logic [WIDTH-1:0] i_enable,
  input wire logic [WIDTH-1:0] i_polarity,
  input wire logic i_block,
  // Result
  output logic o_trigger,
  output logic [WIDTH-1:0] o_level
);
  logic [WIDTH-1:0] sync1;
  logic [WIDTH-1:0] sync2;
  logic [WIDTH-1:0] sync3;
  logic [WIDTH-1:0] stable;
  logic combined;
  logic combined_q;

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      sync1 <= '0;
      sync2 <= '0;
      sync3 <= '0;
    end else begin
      sync1 <= i_pins;
      sync2 <= sync1;
      sync3 <= sync2;
    end
  end

  // Accept a change only when second and third stages agree
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      stable <= '0;
    end else begin
      for (int i = 0; i < WIDTH; i++) begin
        if (sync2[i] == sync3[i]) begin
          stable[i] <= sync3[i];
        end
      end
    end
  end

  // Negative polarity inverts the pin so a falling edge looks like a rising one
  assign combined = |(((stable ^ ~i_polarity)) & i_enable) & ~i_block;

  // Held high combined blocks all other pins until it drops
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      combined_q <= 1'b0;
      o_trigger <= 1'b0;
    end else begin
      combined_q <= combined;
      o_trigger <= combined & ~combined_q;
    end
  end

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      o_level <= '0;
    end else begin
      o_level <= stable;
    end
  end
endmodule

// ===== verilog/peripheral_interrupt_sources.sv
`timescale 1ns/1ps
// Contract
// - Five endpoint requests, one per endpoint.
// - Endpoint request on final handshake: host ack for IN, own ack for OUT.
// - IN transaction without host ack raises no endpoint request.
// - Each enabled analog-port pin interrupts on its selected edge.
// - All analog-port pin triggers share one vector; firmware reads pins.
// - After one analog pin triggers, others blocked until it returns or disabled.
// - No priority among analog pins; enables untouched by acknowledge.
// - Each enabled general pin interrupts; polarity chosen per port.
// - All general pin triggers share one vector.
// - After one general pin triggers, others blocked until return or disable.
// - No priority among general pins; enables untouched by acknowledge.
// - Enabled host parallel port owns general vector, blocks all general pin requests.
// - Host parallel port request gated only by global enable bit 5.
// - Unused bits' enables still steer CMOS output mode, also in config 10.
// - Slave receive interrupts per byte; first byte sets address flag.
// - Slave receive stop sets stop flag and interrupts unless ack was 0.
// - Slave transmit interrupts per byte; ack bit records master ack.
// - Master transmit interrupts per byte; master select cleared issues stop.
// - Master receive interrupts per byte; clearing master select stops.
// - Arbitration loss clears master select, sets flag, interrupts after stop.
// - Proceed bit cleared before interrupt for conditions one to four.
// - Each source event latched pending until serviced or reset; endpoint pending bits here clear only on reset.
// - Analog, general, serial requests use vectors 0x14, 0x16, 0x18; low first.
module peripheral_interrupt_sources
  import irq_src_pkg::*;
#(
  parameter int N_EP = irq_src_pkg::NUM_ENDPOINTS,
  parameter int N_DAC = irq_src_pkg::NUM_DAC_PINS,
  parameter int N_PORT = irq_src_pkg::NUM_GPIO_PORTS,
  parameter int P_W = irq_src_pkg::PORT_WIDTH
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_reset,
  // USB endpoint events from the serial interface engine
  input wire logic [N_EP-1:0] i_ep_in_host_ack,
  input wire logic [N_EP-1:0] i_ep_out_dev_ack,
  input wire logic [N_EP-1:0] i_ep_in_no_ack,
  input wire logic [N_EP-1:0] i_ep_irq_enable,
  // Analog port pins
  input wire logic [N_DAC-1:0] i_dac_pins,
  input wire logic [N_DAC-1:0] i_dac_irq_enable,
  input wire logic [N_DAC-1:0] i_dac_polarity,
  // General-purpose pins
  input wire logic [N_PORT*P_W-1:0] i_gpio_pins,
  input wire logic [N_PORT*P_W-1:0] i_gpio_irq_enable,
  input wire logic [N_PORT*2-1:0] i_port_config,
  // Host parallel port
  input wire logic i_host_parallel_port_enable,
  input wire logic [N_PORT*P_W-1:0] i_host_parallel_port_used,
  input wire logic i_host_parallel_port_event,
  // Global interrupt enable register
  input wire logic [irq_src_pkg::GLOBAL_EN_WIDTH-1:0] i_global_enable,
  // Serial bus engine
  input wire logic [2:0] i_i2c_mode,
  input wire logic i_i2c_byte_done,
  input wire logic i_i2c_first_byte,
  input wire logic i_i2c_stop_seen,
  input wire logic i_i2c_master_acked,
  input wire logic i_i2c_arb_lost,
  // Firmware writes to the serial status and control register
  input wire logic i_ctrl_write,
  input wire logic i_ctrl_proceed,
  input wire logic i_ctrl_master_select,
  input wire logic i_ctrl_ack,
  // CPU acknowledge
  input wire logic i_service,
  // Pending requests and vector
  output logic [N_EP-1:0] o_ep_pending,
  output logic o_dac_pending,
  output logic o_gpio_pending,
  output logic o_i2c_pending,
  output logic o_irq_request,
  output logic [15:0] o_vector,
  // Serial status bits
  output logic o_proceed,
  output logic o_bus_master_select,
  output logic o_arbitration_lost_flag,
  output logic o_addr_flag,
  output logic o_stop_flag,
  output logic o_ack,
  output logic o_issue_stop,
  // Pin levels for firmware and CMOS output mode
  output logic [N_DAC-1:0] o_dac_level,
  output logic [N_PORT*P_W-1:0] o_gpio_level,
  output logic [N_PORT*P_W-1:0] o_cmos_irq_mode
);
  import irq_src_pkg::*;

  localparam int GP_W = N_PORT * P_W;

  logic dac_trigger;
  logic gpio_trigger;
  logic [GP_W-1:0] gpio_polarity;
  logic host_event_q;
  logic host_trigger;
  logic arb_wait;
  logic i2c_event;
  logic byte_event;
  logic slave_stop;
  logic proceed_clear;
  logic [N_EP-1:0] ep_event;
  i2c_mode_type mode;

  // Codes past master receive are unused; treat them as idle
  always_comb begin
    mode = I2C_IDLE;
    if (i_i2c_mode <= I2C_MASTER_RX) begin
      mode = i2c_mode_type'(i_i2c_mode);
    end
  end

  // Per-port polarity from the port configuration low bit
  always_comb begin
    for (int p = 0; p < N_PORT; p++) begin
      gpio_polarity[p*P_W +: P_W] = {P_W{i_port_config[2*p]}};
    end
  end

  pin_edge_lock #(
    .WIDTH(N_DAC)
  ) dac_lock (
    .i_clk(i_clk),
    .i_reset(i_reset),
    .i_pins(i_dac_pins),
    .i_enable(i_dac_irq_enable),
    .i_polarity(i_dac_polarity),
    .i_block(1'b0),
    .o_trigger(dac_trigger),
    .o_level(o_dac_level)
  );

  pin_edge_lock #(
    .WIDTH(GP_W)
  ) gpio_lock (
    .i_clk(i_clk),
    .i_reset(i_reset),
    .i_pins(i_gpio_pins),
    .i_enable(i_gpio_irq_enable),
    .i_polarity(gpio_polarity),
    .i_block(i_host_parallel_port_enable),
    .o_trigger(gpio_trigger),
    .o_level(o_gpio_level)
  );

  // Host port event is on-chip logic, rising edge only
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      host_event_q <= 1'b0;
    end else begin
      host_event_q <= i_host_parallel_port_event;
    end
  end

  // Per-bit enables ignored; only global bit 5 gates it
  assign host_trigger = i_host_parallel_port_enable & i_host_parallel_port_event
    & ~host_event_q & i_global_enable[GLOBAL_HOST_PORT_BIT];

  // Enables keep steering CMOS mode on bits the host port leaves alone
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      o_cmos_irq_mode <= '0;
    end else begin
      for (int p = 0; p < N_PORT; p++) begin
        for (int b = 0; b < P_W; b++) begin
          o_cmos_irq_mode[p*P_W+b] <= i_gpio_irq_enable[p*P_W+b]
            & (i_port_config[2*p +: 2] == PORT_CFG_CMOS_IRQ)
            & ~(i_host_parallel_port_enable & i_host_parallel_port_used[p*P_W+b]);
        end
      end
    end
  end

  // Endpoint events: ack-terminated only, no-ack IN suppressed
  assign ep_event = (i_ep_in_host_ack & ~i_ep_in_no_ack) | i_ep_out_dev_ack;

  // Byte ends and slave-receive stops are conditions one to four
  assign byte_event = i_i2c_byte_done && mode != I2C_IDLE;
  assign slave_stop = i_i2c_stop_seen && mode == I2C_SLAVE_RX && o_ack;
  assign proceed_clear = byte_event || slave_stop;

  // Arbitration loss: flag and master select at once, request after stop
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      arb_wait <= 1'b0;
    end else if (i_i2c_arb_lost) begin
      arb_wait <= 1'b1;
    end else if (arb_wait && i_i2c_stop_seen) begin
      arb_wait <= 1'b0;
    end
  end

  // A firmware write in the stop cycle still clears the flag
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      o_arbitration_lost_flag <= 1'b0;
    end else if (i_i2c_arb_lost) begin
      o_arbitration_lost_flag <= 1'b1;
    end else if (i_ctrl_write) begin
      o_arbitration_lost_flag <= 1'b0;
    end
  end

  always_comb begin
    i2c_event = 1'b0;
    if (arb_wait && i_i2c_stop_seen && !i_i2c_arb_lost) begin
      i2c_event = 1'b1;
    end else if (byte_event) begin
      i2c_event = 1'b1;
    end else if (slave_stop) begin
      i2c_event = 1'b1;
    end
  end

  // Master select: firmware writes it; arbitration loss clears it
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      o_bus_master_select <= 1'b0;
      o_issue_stop <= 1'b0;
    end else begin
      o_issue_stop <= 1'b0;
      if (i_i2c_arb_lost) begin
        o_bus_master_select <= 1'b0;
      end else if (i_ctrl_write) begin
        o_bus_master_select <= i_ctrl_master_select;
        // Dropping master select in master mode ends the transfer with a stop
        if (o_bus_master_select && !i_ctrl_master_select
            && (mode == I2C_MASTER_TX || mode == I2C_MASTER_RX)) begin
          o_issue_stop <= 1'b1;
        end
      end
    end
  end

  // Proceed: hardware clear on byte events wins; firmware sets with one write
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      o_proceed <= 1'b0;
    end else if (proceed_clear) begin
      o_proceed <= 1'b0;
    end else if (i_ctrl_write) begin
      o_proceed <= i_ctrl_proceed;
    end
  end

  // Address flag; set wins over firmware write
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      o_addr_flag <= 1'b0;
    end else if (i_i2c_byte_done && mode == I2C_SLAVE_RX) begin
      o_addr_flag <= i_i2c_first_byte;
    end else if (i_ctrl_write) begin
      o_addr_flag <= 1'b0;
    end
  end

  // Stop flag; set wins over firmware write
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      o_stop_flag <= 1'b0;
    end else if (slave_stop) begin
      o_stop_flag <= 1'b1;
    end else if (i_ctrl_write) begin
      o_stop_flag <= 1'b0;
    end
  end

  // Ack bit: master's ack in slave transmit, otherwise firmware value
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      o_ack <= 1'b0;
    end else if (i_i2c_byte_done && mode == I2C_SLAVE_TX) begin
      o_ack <= i_i2c_master_acked;
    end else if (i_ctrl_write) begin
      o_ack <= i_ctrl_ack;
    end
  end

  // No endpoint vector in this block, so only reset clears these
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      o_ep_pending <= '0;
    end else begin
      for (int e = 0; e < N_EP; e++) begin
        if (ep_event[e] && i_ep_irq_enable[e]) begin
          o_ep_pending[e] <= 1'b1;
        end
      end
    end
  end

  // New events win over the service clear
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      o_dac_pending <= 1'b0;
    end else if (dac_trigger) begin
      o_dac_pending <= 1'b1;
    end else if (i_service && o_vector == VEC_DAC) begin
      o_dac_pending <= 1'b0;
    end
  end

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      o_gpio_pending <= 1'b0;
    end else if (gpio_trigger || host_trigger) begin
      o_gpio_pending <= 1'b1;
    end else if (i_service && o_vector == VEC_GPIO) begin
      o_gpio_pending <= 1'b0;
    end
  end

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      o_i2c_pending <= 1'b0;
    end else if (i2c_event) begin
      o_i2c_pending <= 1'b1;
    end else if (i_service && o_vector == VEC_I2C) begin
      o_i2c_pending <= 1'b0;
    end
  end

  // Fixed priority: lowest vector served first
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      o_vector <= VEC_NONE;
      o_irq_request <= 1'b0;
    end else begin
      o_irq_request <= o_dac_pending | o_gpio_pending | o_i2c_pending;
      if (o_dac_pending && !(i_service && o_vector == VEC_DAC)) begin
        o_vector <= VEC_DAC;
      end else if (o_gpio_pending && !(i_service && o_vector == VEC_GPIO)) begin
        o_vector <= VEC_GPIO;
      end else if (o_i2c_pending && !(i_service && o_vector == VEC_I2C)) begin
        o_vector <= VEC_I2C;
      end else begin
        o_vector <= VEC_NONE;
      end
    end
  end
endmodule

// ===== sim/peripheral_interrupt_sources_asserts.sv
`timescale 1ns/1ps
module peripheral_interrupt_sources_asserts
  import irq_src_pkg::*;
#(
  parameter int N_EP = irq_src_pkg::NUM_ENDPOINTS
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_reset,
  // Events and writes
  input wire logic [N_EP-1:0] i_ep_in_host_ack,
  input wire logic [N_EP-1:0] i_ep_in_no_ack,
  input wire logic [N_EP-1:0] i_ep_out_dev_ack,
  input wire logic [N_EP-1:0] i_ep_irq_enable,
  input wire logic [2:0] i_i2c_mode,
  input wire logic i_i2c_byte_done,
  input wire logic i_i2c_first_byte,
  input wire logic i_i2c_stop_seen,
  input wire logic i_i2c_arb_lost,
  input wire logic i_ctrl_write,
  input wire logic i_ctrl_master_select,
  input wire logic i_service,
  // Observed outputs
  input wire logic [N_EP-1:0] o_ep_pending,
  input wire logic o_dac_pending,
  input wire logic o_gpio_pending,
  input wire logic o_i2c_pending,
  input wire logic [15:0] o_vector,
  input wire logic o_proceed,
  input wire logic o_bus_master_select,
  input wire logic o_arbitration_lost_flag,
  input wire logic o_addr_flag,
  input wire logic o_stop_flag,
  input wire logic o_ack,
  input wire logic o_issue_stop
);
  logic [N_EP-1:0] ep_done;
  // Acknowledged ends only; an IN with no host ack never counts
  assign ep_done = ((i_ep_in_host_ack & ~i_ep_in_no_ack) | i_ep_out_dev_ack) & i_ep_irq_enable;
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_reset);
  sequence s_master_drop;
    i_ctrl_write && !i_ctrl_master_select && o_bus_master_select && i_i2c_mode inside {3'h3, 3'h4};
  endsequence
  sequence s_stop_pulse;
    ##[1:2] o_issue_stop;
  endsequence
  property p_ep_ack;
    ep_done != '0 |=> (o_ep_pending & $past(ep_done)) == $past(ep_done);
  endproperty
  a_ep_ack: assert property (p_ep_ack) else $error("endpoint ack not pending");
  property p_ep_no_ack;
    (o_ep_pending & ~$past(o_ep_pending) & ~$past(ep_done)) == '0;
  endproperty
  a_ep_no_ack: assert property (p_ep_no_ack) else $error("endpoint pending without ack");
  property p_vector;
    o_vector == (($past(o_dac_pending) && !$past(i_service && o_vector == VEC_DAC)) ? VEC_DAC :
      ($past(o_gpio_pending) && !$past(i_service && o_vector == VEC_GPIO)) ? VEC_GPIO :
      ($past(o_i2c_pending) && !$past(i_service && o_vector == VEC_I2C)) ? VEC_I2C : VEC_NONE);
  endproperty
  a_vector: assert property (p_vector) else $error("vector order wrong");
  property p_dac_hold;
    o_dac_pending && !(i_service && o_vector == VEC_DAC) |=> o_dac_pending;
  endproperty
  a_dac_hold: assert property (p_dac_hold) else $error("pending lost");
  property p_proceed;
    $rose(o_i2c_pending) && $past(i_i2c_byte_done) |-> !o_proceed;
  endproperty
  a_proceed: assert property (p_proceed) else $error("proceed still set");
  property p_arb;
    i_i2c_arb_lost |=> !o_bus_master_select && o_arbitration_lost_flag;
  endproperty
  a_arb: assert property (p_arb) else $error("arbitration loss flags");
  property p_master_stop;
    s_master_drop |-> s_stop_pulse;
  endproperty
  a_master_stop: assert property (p_master_stop) else $error("no stop issued");
  property p_addr;
    i_i2c_byte_done && i_i2c_first_byte && i_i2c_mode == 3'h1 |=> o_addr_flag && o_i2c_pending;
  endproperty
  a_addr: assert property (p_addr) else $error("address flag missing");
  property p_stop;
    i_i2c_stop_seen && i_i2c_mode == 3'h1 && o_ack |=> o_stop_flag && o_i2c_pending;
  endproperty
  a_stop: assert property (p_stop) else $error("stop flag missing");
endmodule
bind peripheral_interrupt_sources peripheral_interrupt_sources_asserts #(.N_EP(N_EP)) chk (.*);

// ===== sim/cpu_irq_model.sv
`timescale 1ns/1ps
module cpu_irq_model #(
  parameter int DELAY = 2
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_reset,
  // Request
  input wire logic i_irq_request,
  input wire logic [15:0] i_vector,
  // Acknowledge and serviced counts
  output logic o_service,
  output logic [7:0] o_dac_count,
  output logic [7:0] o_gpio_count,
  output logic [7:0] o_i2c_count
);
  import irq_src_pkg::*;
  int wait_cnt;
  // Holdoff after service: request and vector lag the pending bit
  always @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      o_service <= 1'h0;
      wait_cnt <= 0;
      o_dac_count <= 8'h0;
      o_gpio_count <= 8'h0;
      o_i2c_count <= 8'h0;
    end else if (o_service) begin
      o_service <= #1 1'h0;
      wait_cnt <= -3;
      o_dac_count <= o_dac_count + 8'(i_vector == VEC_DAC);
      o_gpio_count <= o_gpio_count + 8'(i_vector == VEC_GPIO);
      o_i2c_count <= o_i2c_count + 8'(i_vector == VEC_I2C);
    end else if (wait_cnt < 0 || (i_irq_request && wait_cnt < DELAY)) begin
      wait_cnt <= wait_cnt + 1;
    end else if (i_irq_request) begin
      o_service <= #1 1'h1;
      wait_cnt <= 0;
    end
  end
endmodule

// ===== sim/peripheral_interrupt_sources_tb.sv
`timescale 1ns/1ps
module peripheral_interrupt_sources_tb;
  import irq_src_pkg::*;
  logic i_clk = 1'h0;
  logic i_reset = 1'h1;
  logic [4:0] i_ep_in_host_ack = '0, i_ep_out_dev_ack = '0, i_ep_in_no_ack = '0;
  logic [4:0] i_ep_irq_enable = 5'h1F;
  logic [7:0] i_dac_pins = 8'h02, i_dac_irq_enable = '0, i_dac_polarity = 8'h01;
  logic [31:0] i_gpio_pins = 32'h00FF0100, i_gpio_irq_enable = '0;
  logic [31:0] i_host_parallel_port_used = '0;
  logic [7:0] i_port_config = 8'h21, i_global_enable = '0;
  logic i_host_parallel_port_enable = 1'h0, i_host_parallel_port_event = 1'h0;
  logic [2:0] i_i2c_mode = 3'h1;
  logic i_i2c_byte_done = 1'h0, i_i2c_first_byte = 1'h0, i_i2c_stop_seen = 1'h0;
  logic i_i2c_master_acked = 1'h0, i_i2c_arb_lost = 1'h0;
  logic i_ctrl_write = 1'h0, i_ctrl_proceed = 1'h0, i_ctrl_master_select = 1'h0;
  logic i_ctrl_ack = 1'h0;
  logic i_service;
  logic [4:0] o_ep_pending;
  logic o_dac_pending, o_gpio_pending, o_i2c_pending, o_irq_request, o_proceed;
  logic o_bus_master_select, o_arbitration_lost_flag, o_addr_flag, o_stop_flag, o_ack;
  logic o_issue_stop;
  logic [15:0] o_vector;
  logic [7:0] o_dac_level, dac_count, gpio_count, i2c_count;
  logic [31:0] o_gpio_level, o_cmos_irq_mode;
  int errors = 0, tests_run = 0, stops = 0;
  peripheral_interrupt_sources uut (.*);
  cpu_irq_model cpu (.i_clk(i_clk), .i_reset(i_reset), .i_irq_request(o_irq_request),
    .i_vector(o_vector), .o_service(i_service), .o_dac_count(dac_count),
    .o_gpio_count(gpio_count), .o_i2c_count(i2c_count));
  always #50 i_clk = ~i_clk;
  always @(posedge i_clk) if (o_issue_stop === 1'h1) stops++;
  task automatic step(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected %s: expected %h seen %h", name, exp, seen);
    end
  endtask
  // Event bits: byte done, first byte, stop, master acked, arbitration lost
  task automatic i2c(input logic [2:0] mode, input logic [4:0] ev);
    i_i2c_mode = mode;
    {i_i2c_byte_done, i_i2c_first_byte, i_i2c_stop_seen, i_i2c_master_acked, i_i2c_arb_lost} = ev;
    step(1);
    {i_i2c_byte_done, i_i2c_first_byte, i_i2c_stop_seen, i_i2c_master_acked, i_i2c_arb_lost} = '0;
    step(12);
  endtask
  // One write per call, always setting proceed
  task automatic ctrl(input logic ms, input logic ack);
    {i_ctrl_write, i_ctrl_proceed, i_ctrl_master_select, i_ctrl_ack} = {2'h3, ms, ack};
    step(1);
    i_ctrl_write = 1'h0;
    step(3);
  endtask
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial begin
    repeat (3000) @(posedge i_clk);
    errors++;
    end_of_test();
  end
  initial begin
    step(12);
    i_reset = 1'h0;
    step(10);
    i_ep_in_host_ack = 5'h01;
    i_ep_out_dev_ack = 5'h10;
    i_ep_in_no_ack = 5'h04;
    step(1);
    {i_ep_in_host_ack, i_ep_out_dev_ack, i_ep_in_no_ack} = '0;
    step(2);
    check("ep pending", o_ep_pending, 5'h11);
    $display("test endpoints done");
    // Enables only after pins settle, else the reset level looks like an edge
    i_dac_irq_enable = 8'h03;
    step(5);
    i_dac_pins = 8'h03;
    step(15);
    check("dac count", dac_count, 8'h1);
    i_dac_pins = 8'h01;
    step(15);
    check("dac count", dac_count, 8'h1);
    check("dac level", o_dac_level, 8'h01);
    i_dac_pins = 8'h03;
    step(5);
    i_dac_irq_enable = 8'h02;
    step(5);
    i_dac_pins = 8'h01;
    step(15);
    check("dac count", dac_count, 8'h2);
    $display("test dac done");
    i_gpio_irq_enable = 32'h00A50101;
    step(5);
    i_gpio_pins[0] = 1'h1;
    step(15);
    check("gpio count", gpio_count, 8'h1);
    check("gpio level", o_gpio_level, 32'h00FF0101);
    i_gpio_pins[8] = 1'h0;
    step(15);
    check("gpio count", gpio_count, 8'h1);
    i_gpio_pins = 32'h00FF0100;
    step(15);
    i_gpio_pins[0] = 1'h1;
    step(15);
    check("gpio count", gpio_count, 8'h2);
    i_gpio_pins[0] = 1'h0;
    i_host_parallel_port_enable = 1'h1;
    step(15);
    i_gpio_pins[0] = 1'h1;
    step(15);
    check("gpio count", gpio_count, 8'h2);
    i_host_parallel_port_event = 1'h1;
    step(15);
    check("gpio count", gpio_count, 8'h2);
    i_host_parallel_port_event = 1'h0;
    i_global_enable = 8'h20;
    step(3);
    i_host_parallel_port_event = 1'h1;
    step(15);
    check("gpio count", gpio_count, 8'h3);
    check("cmos mode", o_cmos_irq_mode[23:16], 8'hA5);
    i_host_parallel_port_used = 32'h000F0000;
    step(2);
    check("cmos mode", o_cmos_irq_mode[23:16], 8'hA0);
    $display("test gpio done");
    ctrl(1'h0, 1'h1);
    i2c(3'h1, 5'h18);
    check("addr flag", o_addr_flag, 1'h1);
    check("proceed", o_proceed, 1'h0);
    ctrl(1'h0, 1'h1);
    i2c(3'h1, 5'h04);
    check("stop flag", o_stop_flag, 1'h1);
    check("proceed", o_proceed, 1'h0);
    check("i2c count", i2c_count, 8'h2);
    ctrl(1'h0, 1'h0);
    i2c(3'h1, 5'h04);
    check("stop flag", o_stop_flag, 1'h0);
    ctrl(1'h0, 1'h1);
    i2c(3'h2, 5'h10);
    check("ack", o_ack, 1'h0);
    i2c(3'h2, 5'h12);
    check("ack", o_ack, 1'h1);
    check("i2c count", i2c_count, 8'h4);
    i_i2c_mode = 3'h3;
    ctrl(1'h1, 1'h1);
    i2c(3'h3, 5'h10);
    check("proceed", o_proceed, 1'h0);
    ctrl(1'h0, 1'h1);
    check("stops", stops, 8'h1);
    i_i2c_mode = 3'h4;
    ctrl(1'h1, 1'h1);
    i2c(3'h4, 5'h10);
    check("i2c count", i2c_count, 8'h6);
    ctrl(1'h0, 1'h1);
    check("stops", stops, 8'h2);
    ctrl(1'h1, 1'h1);
    i2c(3'h4, 5'h01);
    check("master select", o_bus_master_select, 1'h0);
    check("arb flag", o_arbitration_lost_flag, 1'h1);
    check("i2c count", i2c_count, 8'h6);
    i2c(3'h4, 5'h04);
    check("i2c count", i2c_count, 8'h7);
    $display("test i2c done");
    end_of_test();
  end
endmodule
